/* File: hw/sfe_ctrl.sv */
// Erase, deep power-down and write inhibit sequencer of a serial flash
`timescale 1ns/1ns
module sfe_ctrl #(
  parameter int unsigned PAGE_ERASE_CYC    = sfe_pkg::PAGE_ERASE_CYC,
  parameter int unsigned SECTOR_ERASE_CYC  = sfe_pkg::SECTOR_ERASE_CYC,
  parameter int unsigned WRITE_INHIBIT_CYC = sfe_pkg::WRITE_INHIBIT_CYC
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        spi_clk,
  input  wire logic                        spi_cs_n,
  input  wire logic                        spi_mosi,
  input  wire logic                        protect_bottom,
  input  wire logic                        other_cycle_busy,
  output logic                             cycle_busy_flag,
  output logic                             write_unlock_latch,
  output logic                             deep_sleep,
  output logic                             write_inhibit,
  output sfe_pkg::sfe_erase_t              erase_req
);
  // Link domain: shift register on the serial clock, cleared by select high
  logic [7:0]  lk_op_q;
  logic [23:0] lk_addr_q;
  logic [5:0]  lk_bits_q;
  logic        lk_over_q;
  logic        lk_tog_q;

  always_ff @(posedge spi_clk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      lk_bits_q <= 6'h00;
      lk_over_q <= 1'b0;
      lk_op_q   <= 8'h00;
      lk_addr_q <= 24'h000000;
    end else begin
      if (lk_bits_q < 6'h08) begin
        lk_op_q <= {lk_op_q[6:0], spi_mosi};
      end else if (lk_bits_q < 6'h20) begin
        lk_addr_q <= {lk_addr_q[22:0], spi_mosi};
      end
      if (lk_bits_q == 6'h3f) begin
        lk_over_q <= 1'b1;
      end else begin
        lk_bits_q <= lk_bits_q + 6'h01;
      end
    end
  end

  // Frame end event: select rising flips a toggle; summary stays stable until next frame
  sfe_pkg::sfe_frame_t lk_frame_q;
  always_ff @(posedge spi_cs_n or posedge rst) begin
    if (rst) begin
      lk_tog_q   <= 1'b0;
      lk_frame_q <= '0;
    end else begin
      lk_tog_q   <= ~lk_tog_q;
      lk_frame_q <= '{opcode: lk_op_q, addr: lk_addr_q, bits: lk_bits_q, over: lk_over_q};
    end
  end

  // System domain state
  typedef struct packed {
    logic [2:0]                 tog_sync;
    logic [1:0]                 prot_sync;
    logic [1:0]                 obusy_sync;
    sfe_pkg::sfe_state_t        state;
    logic [sfe_pkg::CNT_W-1:0]  cnt;
    logic [sfe_pkg::CNT_W-1:0]  inh_cnt;
    logic                       inhibit;
    logic                       unlock;
    logic                       busy;
    logic                       sleep;
    sfe_pkg::sfe_erase_t        erase;
  } sfe_ctrl_t;

  sfe_ctrl_t s_q;
  sfe_ctrl_t s_d;

  function automatic logic frame_is(input sfe_pkg::sfe_frame_t f, input logic [7:0] op,
                                    input logic [5:0] nbits);
    frame_is = (f.opcode == op) && (f.bits == nbits) && !f.over;
  endfunction

  logic                       frame_evt;
  logic                       cycle_run;
  logic                       prot_page;
  logic                       prot_sector;
  logic [sfe_pkg::PAGE_W-1:0] page_sel;

  always_comb begin
    s_d       = s_q;
    // Toggle crosses through two flops, third stage feeds the edge detector
    s_d.tog_sync = {s_q.tog_sync[1:0], lk_tog_q};
    frame_evt = s_q.tog_sync[2] ^ s_q.tog_sync[1];
    // Level pins come from outside this clock, two flops before use
    s_d.prot_sync  = {s_q.prot_sync[0], protect_bottom};
    s_d.obusy_sync = {s_q.obusy_sync[0], other_cycle_busy};
    cycle_run = s_q.busy || s_q.obusy_sync[1];
    // Only A16..A8 select a page, upper bits dropped
    page_sel  = lk_frame_q.addr[sfe_pkg::ADDR_USED_MSB:sfe_pkg::PAGE_LSB];
    // Bottom sector is the protected region
    prot_page   = s_q.prot_sync[1] && (page_sel[sfe_pkg::PAGE_W-1] == 1'b0);
    prot_sector = s_q.prot_sync[1] &&
                  (lk_frame_q.addr[sfe_pkg::SECTOR_LSB] == 1'b0);
    s_d.erase.valid = 1'b0;

    if (s_q.inhibit) begin
      if (s_q.inh_cnt == sfe_pkg::CNT_W'(WRITE_INHIBIT_CYC - 1)) begin
        s_d.inhibit = 1'b0;
      end else begin
        s_d.inh_cnt = s_q.inh_cnt + 1'b1;
      end
    end

    case (s_q.state)
      sfe_pkg::SFE_IDLE: begin
        // Standby on select high; sleep only by explicit instruction
        if (frame_evt && !cycle_run) begin
          if (frame_is(lk_frame_q, sfe_pkg::OP_WRITE_UNLOCK, 6'h08) && !s_q.inhibit) begin
            s_d.unlock = 1'b1;
          end else if (s_q.unlock && !s_q.inhibit &&
                       frame_is(lk_frame_q, sfe_pkg::OP_PAGE_ERASE, 6'h20)) begin
            if (!prot_page) begin
              s_d.state  = sfe_pkg::SFE_ERASE;
              s_d.busy   = 1'b1;
              s_d.cnt    = sfe_pkg::CNT_W'(PAGE_ERASE_CYC - 1);
              s_d.erase  = '{valid: 1'b1, sector: 1'b0, page: page_sel};
            end
          end else if (s_q.unlock && !s_q.inhibit &&
                       frame_is(lk_frame_q, sfe_pkg::OP_SECTOR_ERASE, 6'h20)) begin
            if (!prot_sector) begin
              s_d.state  = sfe_pkg::SFE_ERASE;
              s_d.busy   = 1'b1;
              s_d.cnt    = sfe_pkg::CNT_W'(SECTOR_ERASE_CYC - 1);
              s_d.erase  = '{valid: 1'b1, sector: 1'b1, page: page_sel};
            end
          end else if (frame_is(lk_frame_q, sfe_pkg::OP_DEEP_SLEEP, 6'h08)) begin
            s_d.state = sfe_pkg::SFE_ENTER;
            s_d.cnt   = sfe_pkg::CNT_W'(sfe_pkg::SLEEP_ENTRY_CYC - 1);
          end
        end
      end
      sfe_pkg::SFE_ERASE: begin
        // Latch dropped at cycle start, well before completion
        s_d.unlock = 1'b0;
        if (s_q.cnt == '0) begin
          s_d.busy  = 1'b0;
          s_d.state = sfe_pkg::SFE_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      sfe_pkg::SFE_ENTER: begin
        if (s_q.cnt == '0) begin
          s_d.sleep = 1'b1;
          s_d.state = sfe_pkg::SFE_SLEEP;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      sfe_pkg::SFE_SLEEP: begin
        // Everything but an exact wake frame is dropped
        if (frame_evt && !cycle_run &&
            frame_is(lk_frame_q, sfe_pkg::OP_WAKE, 6'h08)) begin
          s_d.state = sfe_pkg::SFE_WAKE;
          s_d.cnt   = sfe_pkg::CNT_W'(sfe_pkg::WAKE_CYC - 1);
        end
      end
      sfe_pkg::SFE_WAKE: begin
        // Frames during the wake delay are ignored; host must stay deselected
        if (s_q.cnt == '0) begin
          s_d.sleep = 1'b0;
          s_d.state = sfe_pkg::SFE_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 1'b1;
        end
      end
      default: begin
        s_d.state = sfe_pkg::SFE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // Power-on state: standby, latch and busy cleared, inhibit running
      s_q         <= '0;
      s_q.state   <= sfe_pkg::SFE_IDLE;
      s_q.inhibit <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign cycle_busy_flag    = s_q.busy;
  assign write_unlock_latch = s_q.unlock;
  assign deep_sleep         = s_q.sleep;
  assign write_inhibit      = s_q.inhibit;
  assign erase_req          = s_q.erase;
endmodule

/* File: hw/sfe_pkg.sv */
// Package with constants and types for the erase and power-down sequencer
package sfe_pkg;
  localparam int unsigned CLK_SYS_HZ       = 50000000;
  // Instruction opcodes, chosen values
  localparam logic [7:0] OP_WRITE_UNLOCK   = 8'h06;
  localparam logic [7:0] OP_PAGE_ERASE     = 8'hdb;
  localparam logic [7:0] OP_SECTOR_ERASE   = 8'hd8;
  localparam logic [7:0] OP_DEEP_SLEEP     = 8'hb9;
  localparam logic [7:0] OP_WAKE           = 8'hab;
  // Address layout
  localparam int unsigned ADDR_USED_MSB    = 16;
  localparam int unsigned PAGE_LSB         = 8;
  localparam int unsigned SECTOR_LSB       = 16;
  localparam int unsigned PAGE_W           = 9;
  localparam int unsigned SECTOR_W         = 1;
  localparam logic [7:0]  ERASED_BYTE      = 8'hff;
  // Times in microseconds
  localparam int unsigned PAGE_ERASE_TIME_US    = 10000;
  localparam int unsigned SECTOR_ERASE_TIME_US  = 1000000;
  localparam int unsigned SLEEP_ENTRY_DELAY_US  = 3;
  localparam int unsigned WAKE_DELAY_US         = 30;
  localparam int unsigned WRITE_INHIBIT_DELAY_US = 1000;
  localparam int unsigned CYC_PER_US       = CLK_SYS_HZ / 1000000;
  localparam int unsigned PAGE_ERASE_CYC   = PAGE_ERASE_TIME_US * CYC_PER_US;
  localparam int unsigned SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * CYC_PER_US;
  localparam int unsigned SLEEP_ENTRY_CYC  = SLEEP_ENTRY_DELAY_US * CYC_PER_US;
  localparam int unsigned WAKE_CYC         = WAKE_DELAY_US * CYC_PER_US;
  localparam int unsigned WRITE_INHIBIT_CYC = WRITE_INHIBIT_DELAY_US * CYC_PER_US;
  localparam int unsigned CNT_W            = 26;

  typedef enum logic [2:0] {
    SFE_IDLE  = 3'b000,
    SFE_ERASE = 3'b001,
    SFE_ENTER = 3'b011,
    SFE_SLEEP = 3'b010,
    SFE_WAKE  = 3'b110
  } sfe_state_t;

  // Frame summary passed from the link domain
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [5:0]  bits;
    logic        over;
  } sfe_frame_t;

  // Erase request to the array
  typedef struct packed {
    logic                valid;
    logic                sector;
    logic [PAGE_W-1:0]   page;
  } sfe_erase_t;
endpackage

/* File: test/sfe_ctrl_assertions.sv */
// Concurrent checks on the sequencer ports
`timescale 1ns/1ns
module sfe_ctrl_chk #(
  parameter int unsigned PAGE_ERASE_CYC   = 40,
  parameter int unsigned SECTOR_ERASE_CYC = 80
) (
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic                protect_bottom,
  input wire logic                cycle_busy_flag,
  input wire logic                write_unlock_latch,
  input wire logic                deep_sleep,
  input wire logic                write_inhibit,
  input wire sfe_pkg::sfe_erase_t erase_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [31:0] cnt_q;
  logic        kind_q;
  // Length judged at the fall, so one counter serves both erase kinds
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q  <= 32'h0;
      kind_q <= 1'b0;
    end else begin
      cnt_q  <= cycle_busy_flag ? cnt_q + 32'h1 : 32'h0;
      kind_q <= erase_req.valid ? erase_req.sector : kind_q;
    end
  end
  sequence erase_start_s;
    erase_req.valid ##1 (!write_unlock_latch && !erase_req.valid);
  endsequence
  busy_start_a: assert property ($rose(cycle_busy_flag) |-> erase_start_s)
    else $error("busy rose without erase start");
  unlock_first_a: assert property (erase_req.valid |-> write_unlock_latch)
    else $error("erase started without unlock");
  busy_reject_a: assert property (erase_req.valid |-> !$past(cycle_busy_flag))
    else $error("erase started during busy");
  protect_low_a: assert property (erase_req.valid && protect_bottom |-> erase_req.page[8])
    else $error("erase into protected sector");
  erase_gate_a: assert property (erase_req.valid |-> !write_inhibit && !deep_sleep)
    else $error("erase during inhibit or sleep");
  unlock_gate_a: assert property ($rose(write_unlock_latch) |-> !write_inhibit && !deep_sleep)
    else $error("unlock during inhibit or sleep");
  busy_len_a: assert property ($fell(cycle_busy_flag) |-> (kind_q ?
    (cnt_q + 1 >= SECTOR_ERASE_CYC && cnt_q <= SECTOR_ERASE_CYC + 1) :
    (cnt_q + 1 >= PAGE_ERASE_CYC && cnt_q <= PAGE_ERASE_CYC + 1)))
    else $error("erase length wrong");
  inhibit_once_a: assert property (!$rose(write_inhibit))
    else $error("inhibit rose after reset");
  sleep_idle_a: assert property ($rose(deep_sleep) |-> !cycle_busy_flag)
    else $error("sleep entered during busy");
endmodule
bind sfe_ctrl sfe_ctrl_chk #(.PAGE_ERASE_CYC(PAGE_ERASE_CYC), .SECTOR_ERASE_CYC(SECTOR_ERASE_CYC))
  u_chk (.clk_sys(clk_sys), .rst(rst), .protect_bottom(protect_bottom),
  .cycle_busy_flag(cycle_busy_flag), .write_unlock_latch(write_unlock_latch),
  .deep_sleep(deep_sleep), .write_inhibit(write_inhibit), .erase_req(erase_req));

/* File: test/sfe_host.sv */
// Serial host model that frames instructions towards the sequencer
`timescale 1ns/1ns
module sfe_host (
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  initial begin
    spi_clk  = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Clock stands still between frames; released data shows the inverse level
  task automatic send(input logic [39:0] word, input int nbits);
    spi_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_mosi = word[39-i];
      #62 spi_clk = 1'b1;
      #63 spi_clk = 1'b0;
    end
    #62 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #500;
  endtask
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the erase and power-down sequencer
`timescale 1ns/1ns
module tb_top;
  localparam int unsigned PG_CYC = 100;
  localparam int unsigned SC_CYC = 200;
  logic                clk_sys = 1'b0;
  logic                rst = 1'b1;
  logic                protect_bottom = 1'b0;
  logic                other_cycle_busy = 1'b0;
  logic                spi_clk;
  logic                spi_cs_n;
  logic                spi_mosi;
  logic                busy;
  logic                unlock;
  logic                sleep;
  logic                inhibit;
  logic                seen = 1'b0;
  sfe_pkg::sfe_erase_t erase_req;
  sfe_pkg::sfe_erase_t last_q;
  int                  fails = 0;
  int                  samples_checked = 0;
  always #10 clk_sys = ~clk_sys;
  sfe_host h (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
  sfe_ctrl #(.PAGE_ERASE_CYC(PG_CYC), .SECTOR_ERASE_CYC(SC_CYC), .WRITE_INHIBIT_CYC(200)) dut (
    .clk_sys(clk_sys), .rst(rst), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .protect_bottom(protect_bottom), .other_cycle_busy(other_cycle_busy),
    .cycle_busy_flag(busy), .write_unlock_latch(unlock), .deep_sleep(sleep),
    .write_inhibit(inhibit), .erase_req(erase_req));
  always @(posedge clk_sys) begin
    if (erase_req.valid === 1'b1) begin
      seen = 1'b1;
      last_q = erase_req;
    end
  end
  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_req(input sfe_pkg::sfe_erase_t got, input sfe_pkg::sfe_erase_t exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t erase got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n);
    seen = 1'b0;
    h.send({op, a, 8'h00}, n);
    cyc(8);
  endtask
  task automatic unl();
    frame(sfe_pkg::OP_WRITE_UNLOCK, 24'h0, 8);
  endtask
  task automatic end_sim();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    end_sim();
  end
  initial begin
    cyc(2);
    chk_flag(busy | unlock | sleep | erase_req.valid, 1'b0);
    chk_flag(inhibit, 1'b1);
    cyc(8);
    rst <= 1'b0;
    unl();
    chk_flag(unlock, 1'b0);
    cyc(200);
    chk_flag(inhibit, 1'b0);
    frame(sfe_pkg::OP_PAGE_ERASE, 24'h0, 32);
    chk_flag(seen, 1'b0);
    unl();
    chk_flag(unlock, 1'b1);
    frame(sfe_pkg::OP_PAGE_ERASE, 24'hfe1234, 32);
    chk_req(last_q, {1'b1, 1'b0, 9'h012});
    chk_flag(busy & ~unlock, 1'b1);
    cyc(PG_CYC);
    chk_flag(busy, 1'b0);
    unl();
    frame(sfe_pkg::OP_SECTOR_ERASE, 24'h00abcd, 32);
    chk_req(last_q, {1'b1, 1'b1, 9'h0ab});
    frame(sfe_pkg::OP_DEEP_SLEEP, 24'h0, 8);
    chk_flag(busy, 1'b1);
    cyc(180);
    chk_flag(sleep | busy, 1'b0);
    protect_bottom <= 1'b1;
    unl();
    frame(sfe_pkg::OP_PAGE_ERASE, 24'h008000, 32);
    chk_flag(seen, 1'b0);
    unl();
    frame(sfe_pkg::OP_SECTOR_ERASE, 24'h000000, 32);
    chk_flag(seen, 1'b0);
    unl();
    frame(sfe_pkg::OP_PAGE_ERASE, 24'h01ff00, 32);
    chk_req(last_q, {1'b1, 1'b0, 9'h1ff});
    cyc(PG_CYC);
    protect_bottom <= 1'b0;
    for (int n = 31; n <= 33; n += 2) begin
      unl();
      frame(sfe_pkg::OP_PAGE_ERASE, 24'h0, n);
      chk_flag(seen, 1'b0);
    end
    other_cycle_busy <= 1'b1;
    unl();
    frame(sfe_pkg::OP_PAGE_ERASE, 24'h0, 32);
    chk_flag(seen, 1'b0);
    other_cycle_busy <= 1'b0;
    frame(sfe_pkg::OP_DEEP_SLEEP, 24'h0, 9);
    cyc(170);
    chk_flag(sleep, 1'b0);
    frame(sfe_pkg::OP_DEEP_SLEEP, 24'h0, 8);
    chk_flag(sleep, 1'b0);
    cyc(150);
    chk_flag(sleep, 1'b1);
    // Latch is still set from a rejected erase, yet in deep sleep an erase here must be ignored
    unl();
    frame(sfe_pkg::OP_PAGE_ERASE, 24'h010000, 32);
    chk_flag(seen, 1'b0);
    frame(sfe_pkg::OP_WAKE, 24'h0, 9);
    cyc(1520);
    chk_flag(sleep, 1'b1);
    frame(sfe_pkg::OP_WAKE, 24'h0, 8);
    chk_flag(sleep, 1'b1);
    cyc(1500);
    chk_flag(sleep, 1'b0);
    end_sim();
  end
endmodule
